// *** rtl/pirq_pkg.sv ***
// constants, carriers and register map of the peripheral interrupt flag block
//==============================================================
// Overview of operation
// RULE_01: an enable bit set lets its request flag raise the interrupt; clear masks it
// RULE_02: request flags set on their event whatever the enable bits say
// RULE_03: software clears pending flags before setting their enables
// RULE_04: pin-change flag is read-only OR of per-pin flags, edge-masked per pin
// RULE_05: timer0 flag sets on overflow, holds until software writes zero
// RULE_06: external pin flag sets on its event, holds until software clears it
// RULE_07: timer1 gate flag sets when the gate closes
// RULE_08: converter flag sets on conversion done, software may clear it
// RULE_09: receive flag is read-only, one while receive buffer holds data
// RULE_10: transmit flag is read-only, one while transmit buffer is empty
// RULE_11: sync serial flag sets on transfer or bus condition done, holds
// RULE_12: bus collision flag sets on collision, holds until cleared
// RULE_13: timer2 flag sets on period match, holds until cleared
// RULE_14: timer1 overflow flag sets on overflow, holds until cleared
// RULE_15: enable register 3 holds eight read/write enables, oscillator fail at top
// RULE_16: enable register 4 holds eight read/write enables, wavegen2 at top
// RULE_17: every enable and request bit resets to zero
// RULE_18: request 0 bits 7-6 and 3-1 ignore writes, read zero
// RULE_19: software sets peripheral enable in control register before any interrupt; here control holds only edge select, request is not gated by it
// RULE_20: external flag uses rising edge if edge select is one, else falling
// RULE_21: pending is flag and enable; OR of pending drives the request
// RULE_22: a hardware set beats a software clear in the same cycle
package pirq_pkg;
   localparam int ADDR_W = 8;
   //==============================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_ENABLE_3 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_4 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_0 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_1 = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_1 = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RISE_EN = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_FALL_EN = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_PIN_FLAGS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h24;
   //==============================================================
   // field positions
   localparam int REQ0_TIMER0_BIT = 5;
   localparam int REQ0_PINCHG_BIT = 4;
   localparam int REQ0_EXT_BIT = 0;
   localparam int REQ1_GATE_BIT = 7;
   localparam int REQ1_CONV_BIT = 6;
   localparam int REQ1_RX_BIT = 5;
   localparam int REQ1_TX_BIT = 4;
   localparam int REQ1_SYNC_BIT = 3;
   localparam int REQ1_BCOL_BIT = 2;
   localparam int REQ1_TMR2_BIT = 1;
   localparam int REQ1_TMR1_BIT = 0;
   localparam int CTRL_EDGE_BIT = 0;
   localparam logic [7:0] REQ0_IMPL_MASK = 8'h31;
   localparam logic [7:0] REQ0_STORE_MASK = 8'h21;
   localparam logic [7:0] REQ1_STORE_MASK = 8'hCF;
   //==============================================================
   // reset values and bus answers
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   //==============================================================
   // carriers
   typedef enum logic [3:0] {SEL_EN3, SEL_EN4, SEL_REQ0, SEL_REQ1, SEL_EN0, SEL_EN1,
                             SEL_RISE, SEL_FALL, SEL_PINF, SEL_CTRL, SEL_NONE} pirq_sel_type;
   typedef enum logic {WR_COLLECT, WR_RESP} pirq_wr_state_type;
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } pirq_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pirq_axi_rsp_type;
   typedef struct packed {
      logic timer0_ovf;
      logic ext_pin;
      logic timer1_gate_closed;
      logic conversion_done;
      logic rx_not_empty;
      logic tx_empty;
      logic sync_serial_done;
      logic bus_collision;
      logic timer2_match;
      logic timer1_ovf;
   } pirq_evt_type;
endpackage

// *** rtl/pirq_flags.sv ***
// peripheral interrupt enable and request registers behind an axi4-lite slave
`timescale 1ns/1ps
module pirq_flags
   import pirq_pkg::*;
#(
   parameter int PIN_COUNT = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pirq_axi_req_type axi_req,
   output pirq_axi_rsp_type axi_rsp,
   input wire pirq_evt_type evt,
   input wire logic [PIN_COUNT-1:0] pin_level,
   output logic [7:0] enable3_out,
   output logic [7:0] enable4_out,
   output logic periph_irq_req
);
   //==============================================================
   // helpers
   function automatic pirq_sel_type reg_sel(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_ENABLE_3: reg_sel = SEL_EN3;
         OFS_ENABLE_4: reg_sel = SEL_EN4;
         OFS_REQUEST_0: reg_sel = SEL_REQ0;
         OFS_REQUEST_1: reg_sel = SEL_REQ1;
         OFS_ENABLE_0: reg_sel = SEL_EN0;
         OFS_ENABLE_1: reg_sel = SEL_EN1;
         OFS_RISE_EN: reg_sel = SEL_RISE;
         OFS_FALL_EN: reg_sel = SEL_FALL;
         OFS_PIN_FLAGS: reg_sel = SEL_PINF;
         OFS_CONTROL: reg_sel = SEL_CTRL;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      merge = (old & ~m) | (d & m);
   endfunction

   //==============================================================
   // state
   pirq_wr_state_type wr_state_q, wr_state_d;
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] en0_q, en1_q, en3_q, en4_q, req0_q, req1_q;
   logic [7:0] en0_d, en1_d, en3_d, en4_d, req0_d, req1_d;
   logic [PIN_COUNT-1:0] rise_q, fall_q, pinf_q, pin_prev_q;
   logic [PIN_COUNT-1:0] rise_d, fall_d, pinf_d;
   logic ctrl_edge_q, ctrl_edge_d, ext_prev_q, irq_q;

   //==============================================================
   // write channel decode
   wire aw_take = axi_req.awvalid & awready_q;
   wire w_take = axi_req.wvalid & wready_q;
   wire wr_go = (wr_state_q == WR_COLLECT) & aw_held_q & w_held_q;
   wire pirq_sel_type wsel = reg_sel(aw_addr_q);
   wire wr_en3 = wr_go & (wsel == SEL_EN3);
   wire wr_en4 = wr_go & (wsel == SEL_EN4);
   wire wr_req0 = wr_go & (wsel == SEL_REQ0);
   wire wr_req1 = wr_go & (wsel == SEL_REQ1);
   wire wr_en0 = wr_go & (wsel == SEL_EN0);
   wire wr_en1 = wr_go & (wsel == SEL_EN1);
   wire wr_rise = wr_go & (wsel == SEL_RISE);
   wire wr_fall = wr_go & (wsel == SEL_FALL);
   wire wr_pinf = wr_go & (wsel == SEL_PINF);
   wire wr_ctrl = wr_go & (wsel == SEL_CTRL);

   // write handshake sequencing
   always_comb begin
      wr_state_d = wr_state_q;
      bvalid_d = bvalid_q;
      if (wr_go) begin
         wr_state_d = WR_RESP;
         bvalid_d = 1'b1;
      end else if (wr_state_q == WR_RESP && axi_req.bready) begin
         wr_state_d = WR_COLLECT;
         bvalid_d = 1'b0;
      end
      aw_held_d = wr_go ? 1'b0 : (aw_held_q | aw_take);
      w_held_d = wr_go ? 1'b0 : (w_held_q | w_take);
      awready_d = (wr_state_d == WR_COLLECT) & ~aw_held_d;
      wready_d = (wr_state_d == WR_COLLECT) & ~w_held_d;
   end

   // write channel registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_state_q <= WR_COLLECT;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
      end else begin
         wr_state_q <= wr_state_d;
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
      end
   end

   // captured address, data and answer code
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_addr_q <= '0;
         w_data_q <= RST_WORD;
         w_strb_q <= 4'h0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (aw_take) aw_addr_q <= axi_req.awaddr;
         if (w_take) w_data_q <= axi_req.wdata;
         if (w_take) w_strb_q <= axi_req.wstrb;
         if (wr_go) bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   //==============================================================
   // event detection
   wire ext_rise = evt.ext_pin & ~ext_prev_q;
   wire ext_fall = ~evt.ext_pin & ext_prev_q;
   wire ext_evt = ctrl_edge_q ? ext_rise : ext_fall; // RULE_20
   wire [PIN_COUNT-1:0] pin_det = (pin_level & ~pin_prev_q & rise_q) | (~pin_level & pin_prev_q & fall_q); // RULE_04
   wire pin_change_any = |pinf_q; // RULE_04
   wire [7:0] set0 = {2'h0, evt.timer0_ovf, 4'h0, ext_evt}; // RULE_05 RULE_06
   wire [7:0] set1 = {evt.timer1_gate_closed, evt.conversion_done, 2'h0, evt.sync_serial_done,
                      evt.bus_collision, evt.timer2_match, evt.timer1_ovf}; // RULE_07 RULE_11 RULE_12 RULE_13 RULE_14
   wire [7:0] req0_view = req0_q | {3'h0, pin_change_any, 4'h0}; // RULE_18
   wire [7:0] req1_view = req1_q | {2'h0, evt.rx_not_empty, evt.tx_empty, 4'h0}; // RULE_09 RULE_10
   wire pending = |(req0_view & en0_q) | |(req1_view & en1_q); // RULE_01 RULE_21

   //==============================================================
   // next values of the register file, hardware set over software write
   always_comb begin
      en3_d = wr_en3 ? 8'(merge({24'h0, en3_q}, w_data_q, w_strb_q)) : en3_q; // RULE_15
      en4_d = wr_en4 ? 8'(merge({24'h0, en4_q}, w_data_q, w_strb_q)) : en4_q; // RULE_16
      en0_d = (wr_en0 ? 8'(merge({24'h0, en0_q}, w_data_q, w_strb_q)) : en0_q) & REQ0_IMPL_MASK;
      en1_d = wr_en1 ? 8'(merge({24'h0, en1_q}, w_data_q, w_strb_q)) : en1_q;
      req0_d = (set0 | (wr_req0 ? 8'(merge({24'h0, req0_q}, w_data_q, w_strb_q)) : req0_q))
               & REQ0_STORE_MASK; // RULE_02 RULE_18 RULE_22
      req1_d = (set1 | (wr_req1 ? 8'(merge({24'h0, req1_q}, w_data_q, w_strb_q)) : req1_q))
               & REQ1_STORE_MASK; // RULE_02 RULE_08 RULE_22
      rise_d = wr_rise ? PIN_COUNT'(merge(32'(rise_q), w_data_q, w_strb_q)) : rise_q;
      fall_d = wr_fall ? PIN_COUNT'(merge(32'(fall_q), w_data_q, w_strb_q)) : fall_q;
      pinf_d = pin_det | (wr_pinf ? PIN_COUNT'(merge(32'(pinf_q), w_data_q, w_strb_q)) : pinf_q); // RULE_22
      ctrl_edge_d = (wr_ctrl & w_strb_q[0]) ? w_data_q[CTRL_EDGE_BIT] : ctrl_edge_q;
   end

   // register file, pin edge enables, pin flags and edge select
   always_ff @(posedge sys_clk) begin
      if (reset) begin // RULE_17
         en0_q <= RST_BYTE;
         en1_q <= RST_BYTE;
         en3_q <= RST_BYTE;
         en4_q <= RST_BYTE;
         req0_q <= RST_BYTE;
         req1_q <= RST_BYTE;
         rise_q <= '0;
         fall_q <= '0;
         pinf_q <= '0;
         ctrl_edge_q <= 1'b0;
      end else begin
         en0_q <= en0_d;
         en1_q <= en1_d;
         en3_q <= en3_d;
         en4_q <= en4_d;
         req0_q <= req0_d;
         req1_q <= req1_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         pinf_q <= pinf_d;
         ctrl_edge_q <= ctrl_edge_d;
      end
   end

   // previous pin levels and registered interrupt request
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ext_prev_q <= 1'b0;
         pin_prev_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ext_prev_q <= evt.ext_pin;
         pin_prev_q <= pin_level;
         irq_q <= pending; // RULE_21
      end
   end

   //==============================================================
   // read channel
   wire ar_take = axi_req.arvalid & arready_q;
   wire pirq_sel_type rsel = reg_sel(axi_req.araddr);
   logic [31:0] rd_mux;
   always_comb begin
      case (rsel)
         SEL_EN3: rd_mux = {24'h0, en3_q};
         SEL_EN4: rd_mux = {24'h0, en4_q};
         SEL_REQ0: rd_mux = {24'h0, req0_view};
         SEL_REQ1: rd_mux = {24'h0, req1_view};
         SEL_EN0: rd_mux = {24'h0, en0_q};
         SEL_EN1: rd_mux = {24'h0, en1_q};
         SEL_RISE: rd_mux = 32'(rise_q);
         SEL_FALL: rd_mux = 32'(fall_q);
         SEL_PINF: rd_mux = 32'(pinf_q);
         SEL_CTRL: rd_mux = {31'h0, ctrl_edge_q};
         default: rd_mux = RST_WORD;
      endcase
      rvalid_d = ar_take | (rvalid_q & ~axi_req.rready);
      arready_d = ~rvalid_d;
   end

   // read answer registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= RST_WORD;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         if (ar_take) rdata_q <= rd_mux;
         if (ar_take) rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   //==============================================================
   // outputs
   assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                      arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
   assign enable3_out = en3_q;
   assign enable4_out = en4_q;
   assign periph_irq_req = irq_q;

   //==============================================================
   // checks
   AST_REQ0_UNIMPL: assert property (@(posedge sys_clk) disable iff (reset) // RULE_18
      (req0_view & ~REQ0_IMPL_MASK) == 8'h00) else $error("request 0 unimplemented bit set");
   AST_TIMER0_SET: assert property (@(posedge sys_clk) disable iff (reset) // RULE_05
      evt.timer0_ovf |=> req0_q[REQ0_TIMER0_BIT]) else $error("timer0 flag not set");
   AST_TIMER0_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // RULE_05
      req0_q[REQ0_TIMER0_BIT] && !wr_req0 |=> req0_q[REQ0_TIMER0_BIT]) else $error("timer0 flag lost");
   AST_SET1_FLAGS: assert property (@(posedge sys_clk) disable iff (reset) // RULE_02
      (set1 != 8'h00) |=> ((req1_q & $past(set1)) == $past(set1))) else $error("request 1 event lost");
   AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (reset) // RULE_22
      wr_req1 && w_strb_q[0] && !w_data_q[REQ1_TMR1_BIT] && evt.timer1_ovf |=> req1_q[REQ1_TMR1_BIT])
      else $error("clear beat set");
   AST_PINCHG_OR: assert property (@(posedge sys_clk) disable iff (reset) // RULE_04
      req0_view[REQ0_PINCHG_BIT] == (pinf_q != '0)) else $error("pin change flag wrong");
   AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (reset) // RULE_20
      !ctrl_edge_q && ext_prev_q && !evt.ext_pin |=> req0_q[REQ0_EXT_BIT]) else $error("falling edge missed");
   AST_RX_LIVE: assert property (@(posedge sys_clk) disable iff (reset) // RULE_09
      req1_view[REQ1_RX_BIT] == evt.rx_not_empty) else $error("receive flag wrong");
   AST_TX_LIVE: assert property (@(posedge sys_clk) disable iff (reset) // RULE_10
      req1_view[REQ1_TX_BIT] == evt.tx_empty) else $error("transmit flag wrong");
   AST_IRQ_MASKED: assert property (@(posedge sys_clk) disable iff (reset) // RULE_01
      en0_q == 8'h00 && en1_q == 8'h00 |=> !periph_irq_req) else $error("masked source interrupted");
   AST_IRQ_PENDING: assert property (@(posedge sys_clk) disable iff (reset) // RULE_21
      req1_q[REQ1_TMR2_BIT] && en1_q[REQ1_TMR2_BIT] |=> periph_irq_req) else $error("pending not raised");
   AST_RESET_ZERO: assert property (@(posedge sys_clk) // RULE_17
      reset |=> en3_q == 8'h00 && en4_q == 8'h00 && req0_q == 8'h00 && req1_q == 8'h00)
      else $error("register not cleared by reset");
   AST_EN3_WRITE: assert property (@(posedge sys_clk) disable iff (reset) // RULE_15
      wr_en3 && w_strb_q[0] |=> en3_q == $past(w_data_q[7:0])) else $error("enable 3 write lost");
endmodule

// *** tb/pirq_evt_model.sv ***
// event source model standing in for the peripherals around the flag block
`timescale 1ns/1ps
module pirq_evt_model
   import pirq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [9:0] fire,
   input wire logic ext_lvl,
   input wire logic rx_lvl,
   input wire logic tx_lvl,
   input wire logic [15:0] pins,
   output pirq_evt_type evt,
   output logic [15:0] pin_level
);
   //==============================================================
   // pulses last one cycle, levels follow the bench one edge late
   always @(posedge sys_clk) begin
      evt <= pirq_evt_type'(fire);
      evt.ext_pin <= ext_lvl;
      evt.rx_not_empty <= rx_lvl;
      evt.tx_empty <= tx_lvl;
      pin_level <= pins;
   end
endmodule

// *** tb/pirq_flags_bench.sv ***
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module pirq_flags_bench
   import pirq_pkg::*;
;
   //==============================================================
   // stimulus and observed signals
   logic sys_clk;
   logic reset;
   pirq_axi_req_type axi_req;
   pirq_axi_rsp_type axi_rsp;
   pirq_evt_type evt;
   logic [9:0] fire;
   logic ext_lvl;
   logic rx_lvl;
   logic tx_lvl;
   logic [15:0] pins;
   logic [15:0] pin_level;
   logic [7:0] en3;
   logic [7:0] en4;
   logic irq;
   int err_count;
   int checks_done;
   pirq_flags u_dut (.sys_clk(sys_clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp), .evt(evt),
      .pin_level(pin_level), .enable3_out(en3), .enable4_out(en4), .periph_irq_req(irq));
   pirq_evt_model u_src (.sys_clk(sys_clk), .fire(fire), .ext_lvl(ext_lvl), .rx_lvl(rx_lvl), .tx_lvl(tx_lvl),
      .pins(pins), .evt(evt), .pin_level(pin_level));
   //==============================================================
   // verdict and hang guard
   task automatic report_and_stop();
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic hang_check(input int n);
      if (n >= 40) begin
         err_count++;
         report_and_stop();
      end
   endtask
   //==============================================================
   // bus cycles: valids held until their own ready edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge sys_clk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'h1;
      axi_req.wvalid <= 1'h1;
      axi_req.bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge sys_clk);
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'h0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'h0;
         if (axi_rsp.bvalid) begin
            r = axi_rsp.bresp;
            axi_req.bready <= 1'h0;
            break;
         end
      end
      hang_check(n);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge sys_clk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'h1;
      axi_req.rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge sys_clk);
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'h0;
         if (axi_rsp.rvalid) begin
            d = axi_rsp.rdata;
            r = axi_rsp.rresp;
            axi_req.rready <= 1'h0;
            break;
         end
      end
      hang_check(n);
   endtask
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      `CHK("write resp", RESP_OKAY, r)
   endtask
   task automatic exp_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(nm, e, d)
      `CHK("read resp", RESP_OKAY, r)
   endtask
   // flag lands one edge after the event, irq one more
   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic pulse(input logic [9:0] m);
      @(posedge sys_clk);
      fire <= m;
      @(posedge sys_clk);
      fire <= '0;
      settle();
   endtask
   //==============================================================
   // scenarios
   task automatic t_reset();
      logic [7:0] ofs [4];
      ofs = '{OFS_ENABLE_3, OFS_ENABLE_4, OFS_REQUEST_0, OFS_REQUEST_1};
      foreach (ofs[i]) exp_rd(ofs[i], RST_WORD, "reset value");
      `CHK("enable outs at reset", 16'h0000, {en3, en4})
   endtask
   task automatic t_enables();
      logic [7:0] pat [2];
      pat = '{8'hA5, 8'h5A};
      foreach (pat[i]) begin
         wr_ok(OFS_ENABLE_3, {24'h0, pat[i]});
         wr_ok(OFS_ENABLE_4, {24'h0, ~pat[i]});
         exp_rd(OFS_ENABLE_3, {24'h0, pat[i]}, "enable 3");
         exp_rd(OFS_ENABLE_4, {24'h0, ~pat[i]}, "enable 4");
         `CHK("enable outs", {pat[i], ~pat[i]}, {en3, en4})
      end
   endtask
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h80, 32'hFFFF_FFFF, r);
      `CHK("unmapped write resp", RESP_SLVERR, r)
      rd(8'h80, d, r);
      `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
      `CHK("enable 3 kept", 8'h5A, en3)
   endtask
   task automatic t_events();
      wr_ok(OFS_REQUEST_0, 32'h0000_00FF);
      exp_rd(OFS_REQUEST_0, 32'h0000_0021, "request 0 write mask");
      wr_ok(OFS_REQUEST_0, RST_WORD);
      pulse(10'h2CF);
      exp_rd(OFS_REQUEST_0, 32'h0000_0020, "timer0 flag");
      exp_rd(OFS_REQUEST_1, 32'h0000_00CF, "request 1 flags");
      `CHK("masked irq", 1'h0, irq)
      exp_rd(OFS_REQUEST_1, 32'h0000_00CF, "flags hold");
      wr_ok(OFS_REQUEST_1, RST_WORD);
      wr_ok(OFS_REQUEST_0, RST_WORD);
      exp_rd(OFS_REQUEST_1, RST_WORD, "request 1 cleared");
      exp_rd(OFS_REQUEST_0, RST_WORD, "request 0 cleared");
   endtask
   task automatic t_levels();
      @(posedge sys_clk);
      rx_lvl <= 1'h1;
      settle();
      wr_ok(OFS_REQUEST_1, 32'h0000_00FF);
      exp_rd(OFS_REQUEST_1, 32'h0000_00EF, "receive live");
      rx_lvl <= 1'h0;
      tx_lvl <= 1'h1;
      settle();
      wr_ok(OFS_REQUEST_1, RST_WORD);
      exp_rd(OFS_REQUEST_1, 32'h0000_0010, "transmit live");
      tx_lvl <= 1'h0;
      settle();
   endtask
   task automatic t_ext();
      logic [1:0] e [4];
      logic [7:0] x [4];
      e = '{2'h3, 2'h2, 2'h1, 2'h0};
      x = '{8'h01, 8'h00, 8'h00, 8'h01};
      for (int i = 0; i < 4; i++) begin
         wr_ok(OFS_CONTROL, {31'h0, e[i][1]});
         ext_lvl <= e[i][0];
         settle();
         exp_rd(OFS_REQUEST_0, {24'h0, x[i]}, "external edge");
         wr_ok(OFS_REQUEST_0, RST_WORD);
      end
   endtask
   task automatic t_pins();
      wr_ok(OFS_RISE_EN, 32'h0000_0008);
      pins <= 16'h0088;
      settle();
      exp_rd(OFS_PIN_FLAGS, 32'h0000_0008, "pin flags");
      wr_ok(OFS_REQUEST_0, RST_WORD);
      exp_rd(OFS_REQUEST_0, 32'h0000_0010, "pin change read only");
      wr_ok(OFS_ENABLE_0, 32'h0000_0010);
      settle();
      `CHK("pin change irq", 1'h1, irq)
      wr_ok(OFS_FALL_EN, 32'h0000_0080);
      pins <= 16'h0000;
      settle();
      exp_rd(OFS_PIN_FLAGS, 32'h0000_0088, "pin fall flags");
      wr_ok(OFS_PIN_FLAGS, RST_WORD);
      settle();
      exp_rd(OFS_REQUEST_0, RST_WORD, "pin change cleared");
      `CHK("irq gone", 1'h0, irq)
      wr_ok(OFS_ENABLE_0, RST_WORD);
   endtask
   task automatic t_irq();
      wr_ok(OFS_REQUEST_1, RST_WORD);
      wr_ok(OFS_ENABLE_1, 32'h0000_0002);
      pulse(10'h001);
      `CHK("other source masked", 1'h0, irq)
      pulse(10'h002);
      `CHK("timer2 irq", 1'h1, irq)
      wr_ok(OFS_ENABLE_1, RST_WORD);
      settle();
      `CHK("masked again", 1'h0, irq)
      wr_ok(OFS_REQUEST_1, RST_WORD);
   endtask
   task automatic t_setwin();
      fork
         wr_ok(OFS_REQUEST_1, RST_WORD);
         begin
            @(posedge sys_clk);
            fire <= 10'h001;
            @(posedge sys_clk);
            fire <= '0;
         end
      join
      exp_rd(OFS_REQUEST_1, 32'h0000_0001, "set beats clear");
   endtask
   task automatic t_rerst();
      wr_ok(OFS_ENABLE_3, 32'h0000_00FF);
      pulse(10'h200);
      `CHK("enable 3 before reset", 8'hFF, en3)
      reset <= 1'h1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'h0;
      t_reset();
   endtask
   //==============================================================
   // clock and main sequence
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      reset = 1'h1;
      axi_req = '0;
      fire = '0;
      ext_lvl = 1'h0;
      rx_lvl = 1'h0;
      tx_lvl = 1'h0;
      pins = '0;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(posedge sys_clk);
      reset <= 1'h0;
      t_reset();
      t_enables();
      t_unmapped();
      t_events();
      t_levels();
      t_ext();
      t_pins();
      t_irq();
      t_setwin();
      t_rerst();
      report_and_stop();
   end
endmodule
